// File: logic/conv_regs_params.svh
// constants of the conversion status and control register logic
`ifndef CONV_REGS_PARAMS_SVH
`define CONV_REGS_PARAMS_SVH

// register addresses on the serial port
`define ADDR_STATUS     6'h00
`define ADDR_CTRL       6'h01
`define ADDR_IFACE      6'h02
`define ADDR_DATA       6'h04

// reset values
`define STATUS_RESET    8'h80
`define CTRL_RESET      16'h0000
`define IFACE_RESET     16'h0000
`define DATA_RESET      24'h00_0000
`define CHAN_RESET      2'h0

// writable bits; reserved bits stay zero
`define CTRL_WR_MASK    16'h877C
`define IFACE_WR_MASK   16'h004D

// clamp values of the stored result
`define DATA_CLAMP_HI   24'hFF_FFFF
`define DATA_CLAMP_LO   24'h00_0000

// interface configuration fields
`define IFACE_APPEND_BIT 6
`define IFACE_CRC_MSB    3
`define IFACE_CRC_LSB    2

// command byte fields
`define CMD_WEN_BIT     7
`define CMD_READ_BIT    6

// bit counts of a frame
`define BYTE_BITS       6'h08
`define WORD16_BITS     6'h10
`define CNT_ONE         6'h01
`define CNT_ZERO        6'h00

// checksum
`define CRC_POLY        8'h07
`define CRC_ZERO        8'h00

// synchroniser vector {cs_n, sync_n, err_n, wr_tgl, rd_tgl}
`define SYNC_WIDTH      5
`define SYNC_RESET      5'h1C

`endif

// File: logic/conv_regs_pkg.sv
// types of the conversion status and control register logic
package conv_regs_pkg;

  // conversion status byte
  typedef struct packed
  {
    logic       rdy_n;
    logic       range_err;
    logic       crc_err;
    logic [2:0] rsvd;
    logic [1:0] result_channel;
  } status_s;

  // conversion control word
  typedef struct packed
  {
    logic       vref_en;
    logic [3:0] rsvd_hi;
    logic [2:0] delay;
    logic       rsvd_mid;
    logic [2:0] mode;
    logic [1:0] clk_sel;
    logic [1:0] rsvd_lo;
  } conv_ctrl_s;

  // one result from the modulator and filter
  typedef struct packed
  {
    logic        over;
    logic        under;
    logic        cal;
    logic [1:0]  channel;
    logic [23:0] value;
  } result_s;

  // one register write handed from the link
  typedef struct packed
  {
    logic [5:0]  addr;
    logic [15:0] data;
    logic        crc_bad;
  } link_wr_s;

  // serial frame states
  typedef enum logic [2:0]
  {
    LS_CMD,
    LS_WDATA,
    LS_CRC,
    LS_READ,
    LS_IDLE
  } link_state_e;

endpackage

// File: logic/sync2.sv
// two flip-flop level synchroniser for a vector of independent bits
`timescale 1ns/1ps

module sync2 #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_r <= RESET_VAL;
      o_sync <= RESET_VAL;
    end
    else if (i_ce)
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// File: logic/crc8_bit.sv
// one serial step of the eight-bit frame checksum
`timescale 1ns/1ps
`include "conv_regs_params.svh"

module crc8_bit (
  // state and incoming bit
  input  wire logic [7:0] i_crc,
  input  wire logic       i_bit,
  // next state
  output logic      [7:0] o_crc
);

  // shift left, fold the polynomial in when the feedback is set
  always_comb
  begin
    o_crc = {i_crc[6:0], 1'b0};
    if (i_crc[7] ^ i_bit)
    begin
      o_crc = o_crc ^ `CRC_POLY;
    end
  end

endmodule

// File: logic/conv_status_regs.sv
// conversion status and control registers behind the four-wire serial port
//
// Contract
// RQ1 - status is an eight-bit read-only register, reset value 0x80
// RQ2 - interface bit 6 appends the status byte to every data read
// RQ3 - chip select low, no read running: data-out pin shows status bit 7
// RQ4 - ready goes low when a result, or calibration result, is written
// RQ5 - a data register read brings ready back high
// RQ6 - overrange clamps to 0xFFFFFF, underrange to 0x000000, both set bit 6
// RQ7 - range error follows each result write, stays until a clean result
// RQ8 - control write or sync pin assertion clears the range error
// RQ9 - when selected, bit 6 shows the error pin input instead
// RQ10 - a write with failing checksum sets bit 5
// RQ11 - reading the status register clears the checksum error
// RQ12 - the host checks checksums of reads itself
// RQ13 - bits 1:0 give the channel of the result held in data
// RQ14 - control write resets filter, resets ready, starts a conversion
// RQ15 - software sets control bits 3:2 to 01 during initialisation
// RQ16 - control bit 15 enables the internal reference and its output
// RQ17 - control register at 0x1, resets to zero, bits 14:11 read zero
// RQ18 - status bits 4:2 read zero; flags synchronous, reset to defaults
`timescale 1ns/1ps
`include "conv_regs_params.svh"

module conv_status_regs (
  // device clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_ce,
  // serial port, link clock domain
  input  wire logic                     i_sclk,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_din,
  output logic                          o_dout,
  output logic                          o_dout_oe,
  // control pins
  input  wire logic                     i_sync_n,
  input  wire logic                     i_err_n,
  input  wire logic                     i_err_in_sel,
  // results from the converter
  input  wire logic                     i_result_valid,
  input  wire conv_regs_pkg::result_s   i_result,
  // converter control
  output conv_regs_pkg::conv_ctrl_s     o_conv_ctrl,
  output logic                          o_vref_enable,
  output logic                          o_filter_reset,
  output logic                          o_conv_start,
  // register state
  output conv_regs_pkg::status_s        o_status,
  output logic [23:0]                   o_data
);

  import conv_regs_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************

  // link domain
  logic                     link_rst_n;
  link_state_e              state_r;
  logic [5:0]               cnt_r;
  logic [15:0]              shin_r;
  logic [15:0]              shin_nxt;
  logic [7:0]               cmd_r;
  logic [7:0]               cmd_nxt;
  logic [15:0]              wdata_r;
  logic [7:0]               crc_r;
  logic [7:0]               crc_nxt;
  logic [5:0]               wlen;
  logic                     crc_on;
  logic                     wr_done;
  logic                     rd_start;
  logic [31:0]              rword;
  logic [31:0]              sh_r;
  logic                     dout_r;
  link_wr_s                 wr_word_r;
  logic                     wr_tgl_r;
  logic [5:0]               rd_addr_r;
  logic                     rd_tgl_r;

  // device domain
  logic [`SYNC_WIDTH-1:0]   sync_out;
  logic                     cs_n_s;
  logic                     sync_n_s;
  logic                     err_n_s;
  logic                     wr_tgl_s;
  logic                     rd_tgl_s;
  logic                     wr_seen_r;
  logic                     rd_seen_r;
  logic                     wr_evt;
  logic                     rd_evt;
  logic                     wr_ok;
  logic                     ctrl_wr;
  logic                     iface_wr;
  logic                     data_rd;
  logic                     status_rd;
  logic                     res_wr;
  logic                     cal_wr;
  logic                     rdy_n_r;
  logic                     range_err_r;
  logic                     crc_err_r;
  logic [1:0]               chan_r;
  logic [23:0]              data_r;
  logic [23:0]              clamp_nxt;
  conv_ctrl_s               ctrl_r;
  logic [15:0]              iface_r;
  logic                     filt_rst_r;
  logic                     conv_start_r;
  status_s                  status_live;
  logic [7:0]               mir_status_r;
  logic [15:0]              mir_ctrl_r;
  logic [15:0]              mir_iface_r;
  logic [23:0]              mir_data_r;

  // ****************************************************************
  // serial frame, link clock domain
  // ****************************************************************

  // frame state is cleared whenever chip select is high
  assign link_rst_n = i_rstn & ~i_cs_n;

  // incoming bits and command byte as they complete
  assign shin_nxt = {shin_r[14:0], i_din};
  assign cmd_nxt  = shin_nxt[7:0];

  // checksum is checked only when the frozen interface word asks for it
  assign crc_on = |mir_iface_r[`IFACE_CRC_MSB:`IFACE_CRC_LSB];

  // checksum over command, data and checksum byte
  crc8_bit u_crc (
    .i_crc (crc_r),
    .i_bit (i_din),
    .o_crc (crc_nxt)
  );

  // write length: the two sixteen-bit registers, one byte otherwise
  always_comb
  begin
    wlen = `BYTE_BITS;
    if ((cmd_r[5:0] == `ADDR_CTRL) || (cmd_r[5:0] == `ADDR_IFACE))
    begin
      wlen = `WORD16_BITS;
    end
  end

  // end-of-write and start-of-read strobes of the frame
  always_comb
  begin
    wr_done  = 1'b0;
    rd_start = 1'b0;
    case (state_r)
      LS_CMD:
      begin
        rd_start = (cnt_r == `BYTE_BITS - `CNT_ONE) && !cmd_nxt[`CMD_WEN_BIT] && cmd_nxt[`CMD_READ_BIT];
      end
      LS_WDATA:
      begin
        wr_done = (cnt_r == wlen - `CNT_ONE) && !crc_on;
      end
      LS_CRC:
      begin
        wr_done = (cnt_r == `BYTE_BITS - `CNT_ONE);
      end
      default:
      begin
        wr_done  = 1'b0;
        rd_start = 1'b0;
      end
    endcase
  end

  // read word, left aligned, from the mirror frozen during the frame
  always_comb
  begin
    case (cmd_nxt[5:0])
      `ADDR_STATUS: rword = {mir_status_r, 24'h00_0000};
      `ADDR_CTRL:   rword = {mir_ctrl_r, 16'h0000};
      `ADDR_IFACE:  rword = {mir_iface_r, 16'h0000};
      `ADDR_DATA:
      begin
        if (mir_iface_r[`IFACE_APPEND_BIT])
        begin
          rword = {mir_data_r, mir_status_r};  // RQ2
        end
        else
        begin
          rword = {mir_data_r, 8'h00};
        end
      end
      default:      rword = 32'h0000_0000;
    endcase
  end

  // frame sequencing on the rising link clock edge
  always_ff @(posedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_r <= LS_CMD;
      cnt_r   <= `CNT_ZERO;
      shin_r  <= 16'h0000;
      cmd_r   <= 8'h00;
      wdata_r <= 16'h0000;
      crc_r   <= `CRC_ZERO;
      sh_r    <= 32'h0000_0000;
    end
    else
    begin
      shin_r <= shin_nxt;
      crc_r  <= crc_nxt;
      sh_r   <= {sh_r[30:0], 1'b0};
      cnt_r  <= cnt_r + `CNT_ONE;
      case (state_r)
        LS_CMD:
        begin
          if (cnt_r == `BYTE_BITS - `CNT_ONE)
          begin
            cmd_r <= cmd_nxt;
            cnt_r <= `CNT_ZERO;
            if (cmd_nxt[`CMD_WEN_BIT])
            begin
              state_r <= LS_IDLE;  // not addressed, ignore rest of frame
            end
            else if (cmd_nxt[`CMD_READ_BIT])
            begin
              state_r <= LS_READ;
              sh_r    <= rword;
            end
            else
            begin
              state_r <= LS_WDATA;
            end
          end
        end
        LS_WDATA:
        begin
          if (cnt_r == wlen - `CNT_ONE)
          begin
            wdata_r <= shin_nxt;
            cnt_r   <= `CNT_ZERO;
            state_r <= crc_on ? LS_CRC : LS_IDLE;
          end
        end
        LS_CRC:
        begin
          if (cnt_r == `BYTE_BITS - `CNT_ONE)
          begin
            state_r <= LS_IDLE;
          end
        end
        LS_READ:
        begin
          cnt_r <= `CNT_ZERO;
        end
        default:
        begin
          cnt_r <= `CNT_ZERO;
        end
      endcase
    end
  end

  // read bits change on the falling link clock edge
  always_ff @(negedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      dout_r <= 1'b0;
    end
    else
    begin
      dout_r <= sh_r[31];
    end
  end

  // completed requests, held across frames, announced by toggles
  always_ff @(posedge i_sclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_word_r <= '0;
      wr_tgl_r  <= 1'b0;
      rd_addr_r <= 6'h00;
      rd_tgl_r  <= 1'b0;
    end
    else
    begin
      if (wr_done)
      begin
        wr_word_r.addr    <= cmd_r[5:0];
        wr_word_r.data    <= (state_r == LS_WDATA) ? shin_nxt : wdata_r;
        wr_word_r.crc_bad <= (state_r == LS_CRC) && (crc_nxt != `CRC_ZERO);
        wr_tgl_r          <= ~wr_tgl_r;
      end
      if (rd_start)
      begin
        rd_addr_r <= cmd_nxt[5:0];
        rd_tgl_r  <= ~rd_tgl_r;
      end
    end
  end

  // ready shows on the pin whenever no register is being read
  assign o_dout    = (state_r == LS_READ) ? dout_r : rdy_n_r;  // RQ3
  assign o_dout_oe = ~i_cs_n;

  // ****************************************************************
  // crossing into the device clock domain
  // ****************************************************************

  // pins and toggles pass two flip-flops
  sync2 #(
    .WIDTH     (`SYNC_WIDTH),
    .RESET_VAL (`SYNC_RESET)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_async ({i_cs_n, i_sync_n, i_err_n, wr_tgl_r, rd_tgl_r}),
    .o_sync  (sync_out)
  );

  assign {cs_n_s, sync_n_s, err_n_s, wr_tgl_s, rd_tgl_s} = sync_out;

  // toggle edge detectors
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_seen_r <= 1'b0;
      rd_seen_r <= 1'b0;
    end
    else if (i_ce)
    begin
      wr_seen_r <= wr_tgl_s;
      rd_seen_r <= rd_tgl_s;
    end
  end

  // decoded events of the device domain
  assign wr_evt    = wr_tgl_s ^ wr_seen_r;
  assign rd_evt    = rd_tgl_s ^ rd_seen_r;
  assign wr_ok     = wr_evt && !wr_word_r.crc_bad;
  assign ctrl_wr   = wr_ok && (wr_word_r.addr == `ADDR_CTRL);
  assign iface_wr  = wr_ok && (wr_word_r.addr == `ADDR_IFACE);
  assign data_rd   = rd_evt && (rd_addr_r == `ADDR_DATA);
  assign status_rd = rd_evt && (rd_addr_r == `ADDR_STATUS);
  assign res_wr    = i_result_valid && !i_result.cal;
  assign cal_wr    = i_result_valid && i_result.cal;

  // ****************************************************************
  // control and interface registers
  // ****************************************************************

  // writable fields only; reserved bits hold zero
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_r  <= `CTRL_RESET;  // RQ17
      iface_r <= `IFACE_RESET;
    end
    else if (i_ce)
    begin
      if (ctrl_wr)
      begin
        ctrl_r <= wr_word_r.data & `CTRL_WR_MASK;  // RQ17
      end
      if (iface_wr)
      begin
        iface_r <= wr_word_r.data & `IFACE_WR_MASK;
      end
    end
  end

  // one-cycle filter reset and conversion start on a control write
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      filt_rst_r   <= 1'b0;
      conv_start_r <= 1'b0;
    end
    else if (i_ce)
    begin
      filt_rst_r   <= ctrl_wr;  // RQ14
      conv_start_r <= ctrl_wr;  // RQ14
    end
  end

  // ****************************************************************
  // status flags and data register
  // ****************************************************************

  // stored result is clamped on either range error
  always_comb
  begin
    clamp_nxt = i_result.value;
    if (i_result.over)
    begin
      clamp_nxt = `DATA_CLAMP_HI;  // RQ6
    end
    else if (i_result.under)
    begin
      clamp_nxt = `DATA_CLAMP_LO;  // RQ6
    end
  end

  // data register and channel of the held result
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      data_r <= `DATA_RESET;
      chan_r <= `CHAN_RESET;
    end
    else if (i_ce && res_wr)
    begin
      data_r <= clamp_nxt;
      chan_r <= i_result.channel;  // RQ13
    end
  end

  // ready flag, active low; a new result wins over a clearing access
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rdy_n_r <= 1'(`STATUS_RESET >> 7);  // RQ18
    end
    else if (i_ce)
    begin
      if (res_wr || cal_wr)
      begin
        rdy_n_r <= 1'b0;  // RQ4
      end
      else if (data_rd || ctrl_wr)
      begin
        rdy_n_r <= 1'b1;  // RQ5 RQ14
      end
    end
  end

  // range error follows each non-calibration result, cleared by control write or sync
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      range_err_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (res_wr)
      begin
        range_err_r <= i_result.over | i_result.under;  // RQ6 RQ7
      end
      else if (ctrl_wr || !sync_n_s)
      begin
        range_err_r <= 1'b0;  // RQ8
      end
    end
  end

  // checksum error; a failing write wins over a status read
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      crc_err_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (wr_evt && wr_word_r.crc_bad)
      begin
        crc_err_r <= 1'b1;  // RQ10
      end
      else if (status_rd)
      begin
        crc_err_r <= 1'b0;  // RQ11
      end
    end
  end

  // live status byte
  always_comb
  begin
    status_live                = '0;  // RQ18
    status_live.rdy_n          = rdy_n_r;
    status_live.range_err      = i_err_in_sel ? !err_n_s : range_err_r;  // RQ9
    status_live.crc_err        = crc_err_r;
    status_live.result_channel = chan_r;  // RQ13
  end

  // ****************************************************************
  // read mirror, frozen while chip select is low
  // ****************************************************************

  // the link reads these only inside a frame, when they stand still
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mir_status_r <= `STATUS_RESET;  // RQ1
      mir_ctrl_r   <= `CTRL_RESET;
      mir_iface_r  <= `IFACE_RESET;
      mir_data_r   <= `DATA_RESET;
    end
    else if (i_ce && cs_n_s)
    begin
      mir_status_r <= status_live;  // RQ1
      mir_ctrl_r   <= ctrl_r;
      mir_iface_r  <= iface_r;
      mir_data_r   <= data_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // control word and reference enable drive the converter
  assign o_conv_ctrl    = ctrl_r;
  assign o_vref_enable  = ctrl_r.vref_en;  // RQ16
  assign o_filter_reset = filt_rst_r;
  assign o_conv_start   = conv_start_r;
  assign o_status       = status_live;
  assign o_data         = data_r;

endmodule

// File: testbench/conv_status_regs_assertions.sv
// port assertions of the status and control register logic
`timescale 1ns/1ps

module conv_status_regs_checker (
  // device clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_rstn,
  input wire logic                   i_ce,
  // pins
  input wire logic                   i_cs_n,
  input wire logic                   o_dout_oe,
  input wire logic                   i_sync_n,
  input wire logic                   i_err_in_sel,
  // results
  input wire logic                   i_result_valid,
  input wire conv_regs_pkg::result_s i_result,
  // outputs
  input wire conv_regs_pkg::conv_ctrl_s o_conv_ctrl,
  input wire logic                   o_vref_enable,
  input wire logic                   o_filter_reset,
  input wire logic                   o_conv_start,
  input wire conv_regs_pkg::status_s o_status,
  input wire logic [23:0]            o_data
);
  import conv_regs_pkg::*;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // a plain result taken at this edge
  logic res_v;
  assign res_v = i_ce && i_result_valid && !i_result.cal;

  // ****************************************
  // status byte and data register
  // ****************************************
  status_rsvd_a: assert property (o_status.rsvd == 3'h0)
    else $error("status reserved bits not zero");
  result_load_a: assert property (res_v |=> !o_status.rdy_n &&
    o_status.result_channel == $past(i_result.channel))
    else $error("result load wrong");
  clamp_high_a: assert property (res_v && i_result.over |=> o_data == 24'hFF_FFFF)
    else $error("overrange not clamped");
  clamp_low_a: assert property (res_v && i_result.under && !i_result.over |=> o_data == 24'h00_0000)
    else $error("underrange not clamped");
  range_follow_a: assert property (res_v && !i_err_in_sel ##1 !i_err_in_sel |->
    o_status.range_err == $past(i_result.over || i_result.under))
    else $error("range flag wrong");
  cal_ready_a: assert property (i_ce && i_result_valid && i_result.cal |=> !o_status.rdy_n && $stable(o_data))
    else $error("calibration result wrong");
  sync_clear_a: assert property ((!i_sync_n && !i_result_valid && !i_err_in_sel) [*5] |-> !o_status.range_err)
    else $error("sync did not clear range");

  // ****************************************
  // control and pins
  // ****************************************
  pulse_pair_a: assert property (o_filter_reset |-> o_conv_start ##1 !o_conv_start)
    else $error("pulses differ");
  ctrl_rsvd_a: assert property (o_conv_ctrl.rsvd_hi == 4'h0)
    else $error("control reserved bits not zero");
  vref_bit_a: assert property (o_vref_enable == o_conv_ctrl.vref_en)
    else $error("reference enable wrong");
  dout_drive_a: assert property (o_dout_oe == !i_cs_n)
    else $error("data-out enable wrong");
endmodule

// File: testbench/host_model.sv
// serial host on the four-wire port, clock idle high
`timescale 1ns/1ps

module host_model (
  // serial port
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din,
  input  wire logic i_dout
);
  // idle: clock high, not selected
  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din  = 1'b1;
  end

  // one frame: nw bits out msb first, then nr bits back
  task automatic xfer(input logic [31:0] bits, input int nw, input int nr,
                      output logic [31:0] rd, output logic rdy);
    rd = 32'h0000_0000;
    o_cs_n = 1'b0;
    #40;
    rdy = i_dout; // ready mirror before any bit
    for (int i = 0; i < nw + nr; i++)
    begin
      o_sclk = 1'b0;
      if (i < nw)
        o_din = bits[31 - i];
      #32;
      o_sclk = 1'b1;
      if (i >= nw)
        rd = {rd[30:0], i_dout};
      #32;
    end
    o_cs_n = 1'b1;
    o_din = ~o_din; // released line never keeps a stale level
    #60;
  endtask
endmodule

// File: testbench/test_conv_status_regs.sv
// testbench of the status and control register logic
`timescale 1ns/1ps

module test_conv_status_regs;
  import conv_regs_pkg::*;

  logic        i_clk;
  logic        i_rstn;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        i_sync_n;
  logic        i_err_n;
  logic        i_err_in_sel;
  logic        i_result_valid;
  result_s     i_result;
  conv_ctrl_s  o_conv_ctrl;
  logic        o_vref_enable;
  logic        o_filter_reset;
  logic        o_conv_start;
  status_s     o_status;
  logic [23:0] o_data;
  logic [31:0] rd;
  logic        rdy;
  int          num_errors;
  int          check_count;
  int          cycles;
  int          pulses;

  host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout_oe ? dout : ~dout));

  conv_status_regs dut (
    .i_clk, .i_rstn, .i_ce(1'b1),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
    .i_sync_n, .i_err_n, .i_err_in_sel, .i_result_valid, .i_result,
    .o_conv_ctrl, .o_vref_enable, .o_filter_reset, .o_conv_start, .o_status, .o_data);

  // device clock and hang guard
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (o_filter_reset === 1'b1)
      pulses++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic result(input logic o, input logic u, input logic c, input logic [1:0] ch, input logic [23:0] v);
    @(negedge i_clk);
    i_result_valid = 1'b1;
    i_result = {o, u, c, ch, v};
    @(negedge i_clk);
    i_result_valid = 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check(32'(o_status), 32'h0000_0080);
    check(32'(o_conv_ctrl), 32'h0000_0000);
    check(32'(o_data), 32'h0000_0000);
    host.xfer(32'h4000_0000, 8, 8, rd, rdy);
    check(rd, 32'h0000_0080);
    check(32'(rdy), 32'h0000_0001);
    host.xfer(32'h4300_0000, 8, 16, rd, rdy); // unmapped address reads zero
    check(rd, 32'h0000_0000);
  endtask

  task automatic t_results();
    result(1'b1, 1'b0, 1'b0, 2'h2, 24'h12_3456);
    check(32'(o_data), 32'h00FF_FFFF);
    check(32'(o_status), 32'h0000_0042);
    result(1'b0, 1'b1, 1'b0, 2'h3, 24'h65_4321);
    check(32'(o_data), 32'h0000_0000);
    check(32'(o_status), 32'h0000_0043);
    result(1'b0, 1'b0, 1'b0, 2'h1, 24'hA5_5A01);
    check(32'(o_status), 32'h0000_0001);
  endtask

  task automatic t_read();
    result(1'b0, 1'b0, 1'b0, 2'h0, 24'h3C_C3F0);
    host.xfer(32'h4400_0000, 8, 24, rd, rdy);
    check(32'(rdy), 32'h0000_0000);
    check(rd, 32'h003C_C3F0);
    check(32'(o_status), 32'h0000_0080);
    result(1'b0, 1'b0, 1'b1, 2'h2, 24'h11_1111);
    check(32'(o_status), 32'h0000_0000);
    check(32'(o_data), 32'h003C_C3F0);
  endtask

  task automatic t_ctrl();
    result(1'b1, 1'b0, 1'b0, 2'h1, 24'h00_0001);
    pulses = 0;
    host.xfer(32'h01FF_FF00, 24, 0, rd, rdy);
    check(32'(pulses), 32'h0000_0001);
    check(32'(o_conv_ctrl), 32'h0000_877C);
    check(32'(o_vref_enable), 32'h0000_0001);
    check(32'(o_status), 32'h0000_0081);
    host.xfer(32'h0100_0400, 24, 0, rd, rdy);
    check(32'(o_conv_ctrl), 32'h0000_0004);
    check(32'(o_vref_enable), 32'h0000_0000);
  endtask

  task automatic t_append();
    result(1'b0, 1'b0, 1'b0, 2'h3, 24'hC0_FFEE);
    host.xfer(32'h0200_4000, 24, 0, rd, rdy);
    host.xfer(32'h4400_0000, 8, 32, rd, rdy);
    check(rd, 32'hC0FF_EE03);
  endtask

  task automatic t_pins();
    result(1'b1, 1'b0, 1'b0, 2'h2, 24'h00_0002);
    i_sync_n = 1'b0;
    repeat (6) @(negedge i_clk);
    check(32'(o_status.range_err), 32'h0000_0000);
    i_sync_n = 1'b1;
    i_err_in_sel = 1'b1;
    i_err_n = 1'b0;
    repeat (5) @(negedge i_clk);
    check(32'(o_status.range_err), 32'h0000_0001);
    i_err_n = 1'b1;
    repeat (5) @(negedge i_clk);
    check(32'(o_status.range_err), 32'h0000_0000);
    i_err_in_sel = 1'b0;
  endtask

  task automatic t_crc();
    host.xfer(32'h0200_0400, 24, 0, rd, rdy);
    pulses = 0;
    host.xfer(32'h0100_0000, 32, 0, rd, rdy); // zero is not this frame's checksum
    check(32'(o_status.crc_err), 32'h0000_0001);
    check(32'(o_conv_ctrl), 32'h0000_0004);
    check(32'(pulses), 32'h0000_0000);
    host.xfer(32'h4000_0000, 8, 8, rd, rdy);
    check(rd, 32'h0000_0022);
    check(32'(o_status.crc_err), 32'h0000_0000);
  endtask

  // main sequence
  initial
  begin
    i_rstn = 1'b0;
    i_sync_n = 1'b1;
    i_err_n = 1'b1;
    i_err_in_sel = 1'b0;
    i_result_valid = 1'b0;
    i_result = '0;
    repeat (2) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk);
    t_reset();
    t_results();
    t_read();
    t_ctrl();
    t_append();
    t_pins();
    t_crc();
    complete_run();
  end
endmodule

bind conv_status_regs conv_status_regs_checker chk (
  .i_clk, .i_rstn, .i_ce, .i_cs_n, .o_dout_oe, .i_sync_n, .i_err_in_sel, .i_result_valid,
  .i_result, .o_conv_ctrl, .o_vref_enable, .o_filter_reset, .o_conv_start, .o_status, .o_data);
